// >>> inc/sbh_pkg.sv
`default_nettype none
package sbh_pkg;
  // ****************************************************
  // bus format codes on the four mode pins
  // ****************************************************
  localparam logic [3:0] SBH_FMT_P16_I  = 4'h0;
  localparam logic [3:0] SBH_FMT_P8_I   = 4'h1;
  localparam logic [3:0] SBH_FMT_P16_II = 4'h2;
  localparam logic [3:0] SBH_FMT_P8_II  = 4'h3;
  localparam logic [3:0] SBH_FMT_P18_I  = 4'h8;
  localparam logic [3:0] SBH_FMT_P9_I   = 4'h9;
  localparam logic [3:0] SBH_FMT_P18_II = 4'ha;
  localparam logic [3:0] SBH_FMT_P9_II  = 4'hb;
  localparam logic [2:0] SBH_FMT_SER3   = 3'h2;
  localparam logic [2:0] SBH_FMT_SER4   = 3'h3;

  // ****************************************************
  // widths, positions and reset values
  // ****************************************************
  localparam int         SBH_DW          = 18;
  localparam logic [7:0] SBH_MEM_INDEX   = 8'h22;
  localparam logic [7:0] SBH_INDEX_RST   = 8'h00;
  localparam logic [17:0] SBH_LATCH_RST  = 18'h00000;
  localparam logic [3:0] SBH_SER4_BITS   = 4'h8;
  localparam logic [3:0] SBH_SER3_BITS   = 4'h9;
  localparam logic [3:0] SBH_BITCNT_RST  = 4'h0;
  localparam int         SBH_FIFO_DEPTH  = 4;

  // ****************************************************
  // sampled host pins
  // ****************************************************
  typedef struct packed {
    logic        cs_n;
    logic        dnc;
    logic        wr_n;
    logic        rd_n;
    logic [17:0] data;
    logic        sin;
  } sbh_pins_type;

  localparam sbh_pins_type SBH_PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b1,
                                            18'h00000, 1'b0};

  // register write handed to the command side
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] value;
  } sbh_regwr_type;
endpackage
`default_nettype wire

// >>> logic/sbh_host_if.sv
// Functional notes
// - transfers only count while chip select is low; otherwise ignored
// - command/data select steers an access to command path or frame memory
// - mode 0000: 16-bit type I, registers on D7-D0, memory D15-D0
// - mode 0001: 8-bit type I, everything on D7-D0
// - mode 0010: 16-bit type II, registers D8-D1, memory D17-D10 and D8-D1
// - mode 0011: 8-bit type II, everything on D17-D10
// - mode 1000: 18-bit type I, registers D7-D0, memory D17-D0
// - mode 1001: 9-bit type I, registers D7-D0, memory D8-D0
// - mode 1010: 18-bit type II, registers D8-D1, memory D17-D0
// - mode 1011: 9-bit type II, registers D17-D10, memory D17-D9
// - upper mode 010: 3-wire serial, low pin is id, strobe is clock
// - upper mode 011: 4-wire serial with select, clock and in; the out pin is never driven
// - select low: write loads index outside video mode, read returns internal status
// - index kept as pointer for later select-high accesses
// - select high write goes to indexed register or frame memory
// - select high read returns indexed register or memory data
// - memory data goes to a write latch, then moves on by itself
// - memory reads pass a read latch; first read is a dummy
// - video mode pixels are shown directly, never stored
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// small fifo between write latch and frame memory
// ****************************************************
module sbh_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ****************************************************
// system bus host interface
// ****************************************************
module sbh_host_if
  import sbh_pkg::*;
#(
  parameter int FIFO_DEPTH = SBH_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  // host pins
  input  wire logic        CHIP_SELECT_N,
  input  wire logic        CMD_DATA_SEL_OR_SERIAL_CLK,
  input  wire logic        WRITE_STROBE_OR_SERIAL_CLK,
  input  wire logic        READ_STROBE_N,
  input  wire logic [3:0]  BUS_FORMAT_SEL,
  input  wire logic [17:0] HOST_DATA_PINS_I,
  output logic [17:0]      HOST_DATA_PINS_O,
  output logic             HOST_DATA_PINS_OE,
  input  wire logic        SERIAL_IN,
  output logic             SERIAL_OUT,
  output logic             SERIAL_OUT_OE,
  input  wire logic        VIDEO_MODE,
  // command register side
  output logic             REG_WR_VALID,
  output sbh_regwr_type    REG_WR,
  output logic [7:0]       INDEX_POINTER_REG,
  input  wire logic [7:0]  REG_RD_DATA,
  input  wire logic [7:0]  STATUS_IN,
  // frame memory side
  output logic             FM_WR_VALID,
  input  wire logic        FM_WR_READY,
  output logic [17:0]      FM_WR_DATA,
  output logic             FM_RD_REQ,
  input  wire logic [17:0] FM_RD_DATA,
  output logic             HOST_WR_BUSY,
  // video bypass
  output logic             VIDEO_PIX_VALID,
  output logic [17:0]      VIDEO_PIX,
  // status
  output logic             MODE_INVALID
);
  // ****************************************************
  // lane helpers
  // ****************************************************
  // register byte lanes per format
  function automatic logic [7:0] reg_byte(input logic [3:0] f,
                                          input logic [17:0] d);
    case (f)
      SBH_FMT_P16_II, SBH_FMT_P18_II: reg_byte = d[8:1];
      SBH_FMT_P8_II, SBH_FMT_P9_II:   reg_byte = d[17:10];
      default:                        reg_byte = d[7:0];
    endcase
  endfunction

  // frame memory lanes per format, right aligned
  function automatic logic [17:0] mem_word(input logic [3:0] f,
                                           input logic [17:0] d);
    case (f)
      SBH_FMT_P16_I:  mem_word = {2'h0, d[15:0]};
      SBH_FMT_P8_I:   mem_word = {10'h000, d[7:0]};
      SBH_FMT_P16_II: mem_word = {2'h0, d[17:10], d[8:1]};
      SBH_FMT_P8_II:  mem_word = {10'h000, d[17:10]};
      SBH_FMT_P9_I:   mem_word = {9'h000, d[8:0]};
      SBH_FMT_P9_II:  mem_word = {9'h000, d[17:9]};
      default:        mem_word = d;
    endcase
  endfunction

  // reverse mapping for driving read data back out
  function automatic logic [17:0] place_reg(input logic [3:0] f,
                                            input logic [7:0] b);
    case (f)
      SBH_FMT_P16_II, SBH_FMT_P18_II: place_reg = {9'h000, b, 1'b0};
      SBH_FMT_P8_II, SBH_FMT_P9_II:   place_reg = {b, 10'h000};
      default:                        place_reg = {10'h000, b};
    endcase
  endfunction

  function automatic logic [17:0] place_mem(input logic [3:0] f,
                                            input logic [17:0] w);
    case (f)
      SBH_FMT_P16_II: place_mem = {w[15:8], 1'b0, w[7:0], 1'b0};
      SBH_FMT_P8_II:  place_mem = {w[7:0], 10'h000};
      SBH_FMT_P9_II:  place_mem = {w[8:0], 9'h000};
      SBH_FMT_P16_I:  place_mem = {2'h0, w[15:0]};
      SBH_FMT_P8_I:   place_mem = {10'h000, w[7:0]};
      SBH_FMT_P9_I:   place_mem = {9'h000, w[8:0]};
      default:        place_mem = w;
    endcase
  endfunction

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  sbh_pins_type pins;
  sbh_pins_type s1_r;
  sbh_pins_type s2_r;
  sbh_pins_type prev_r;
  logic [3:0]   fmt_s1_r;
  logic [3:0]   fmt_r;

  assign pins = '{CHIP_SELECT_N, CMD_DATA_SEL_OR_SERIAL_CLK,
                  WRITE_STROBE_OR_SERIAL_CLK, READ_STROBE_N,
                  HOST_DATA_PINS_I, SERIAL_IN};

  // two flops before anything looks at a pin other than VIDEO_MODE
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_r     <= SBH_PINS_RST;
      s2_r     <= SBH_PINS_RST;
      prev_r   <= SBH_PINS_RST;
      fmt_s1_r <= SBH_FMT_P8_I;
      fmt_r    <= SBH_FMT_P8_I;
    end else begin
      s1_r     <= pins;
      s2_r     <= s1_r;
      prev_r   <= s2_r;
      fmt_s1_r <= BUS_FORMAT_SEL;
      fmt_r    <= fmt_s1_r;
    end
  end

  // ****************************************************
  // format decode and access events
  // ****************************************************
  logic is_ser3;
  logic is_ser4;
  logic is_par;
  logic selected;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  logic scl_rise;

  assign is_ser3  = (fmt_r[3:1] == SBH_FMT_SER3);
  assign is_ser4  = (fmt_r[3:1] == SBH_FMT_SER4);
  assign is_par   = (fmt_r[3:2] == 2'b00)
                    || (fmt_r[3:2] == 2'b10);
  // write ends, read starts and serial clock rises count only while selected now and one cycle ago
  assign selected = !s2_r.cs_n && !prev_r.cs_n;
  assign wr_end   = selected && is_par && !prev_r.wr_n && s2_r.wr_n
                    && s2_r.rd_n;
  assign rd_start = selected && is_par && prev_r.rd_n && !s2_r.rd_n
                    && s2_r.wr_n;
  assign rd_end   = is_par && !prev_r.rd_n && s2_r.rd_n;
  assign scl_rise = selected && !prev_r.wr_n && s2_r.wr_n;

  // ****************************************************
  // serial shifter
  // ****************************************************
  logic [8:0] sh_r;
  logic [3:0] bitcnt_r;
  logic [3:0] ser_len;
  logic       ser_done;
  logic [8:0] sh_nxt;
  logic       ser_dnc;

  assign ser_len  = is_ser3 ? SBH_SER3_BITS : SBH_SER4_BITS;
  assign sh_nxt   = {sh_r[7:0], s2_r.sin};
  assign ser_done = scl_rise && (is_ser3 || is_ser4)
                    && (bitcnt_r == ser_len - 4'h1);
  // 3-wire frames carry select as first bit; 4-wire uses the pin
  assign ser_dnc  = is_ser3 ? sh_r[7] : s2_r.dnc;

  // a deselect restarts framing so a torn frame cannot shift bits
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sh_r     <= '0;
      bitcnt_r <= SBH_BITCNT_RST;
    end else if (s2_r.cs_n || ser_done) begin
      bitcnt_r <= SBH_BITCNT_RST;
    end else if (scl_rise && (is_ser3 || is_ser4)) begin
      sh_r     <= sh_nxt;
      bitcnt_r <= bitcnt_r + 4'h1;
    end
  end

  // ****************************************************
  // unified write decode
  // ****************************************************
  logic        any_wr;
  logic        wr_dnc;
  logic [7:0]  wr_byte;
  logic [17:0] wr_word;
  logic        to_mem;

  assign any_wr  = wr_end || ser_done;
  assign wr_dnc  = ser_done ? ser_dnc : s2_r.dnc;
  assign wr_byte = ser_done ? sh_nxt[7:0] : reg_byte(fmt_r, s2_r.data);
  assign wr_word = ser_done ? {10'h000, sh_nxt[7:0]}
                            : mem_word(fmt_r, s2_r.data);
  assign to_mem  = wr_dnc && (INDEX_POINTER_REG == SBH_MEM_INDEX);

  // index pointer, reloaded by every select-low write outside video mode
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      INDEX_POINTER_REG <= SBH_INDEX_RST;
    end else if (any_wr && !wr_dnc && !VIDEO_MODE) begin
      INDEX_POINTER_REG <= wr_byte;
    end
  end

  // command register writes as a one-cycle pulse
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_WR_VALID <= 1'b0;
      REG_WR       <= '0;
    end else begin
      REG_WR_VALID <= any_wr && wr_dnc && !to_mem;
      if (any_wr && wr_dnc && !to_mem) begin
        REG_WR <= '{INDEX_POINTER_REG, wr_byte};
      end
    end
  end

  // ****************************************************
  // write latch and memory queue
  // ****************************************************
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [17:0] fifo_out_data;
  logic        drain;
  logic        push;

  // video mode keeps pixels away from the memory path
  assign push  = any_wr && to_mem && !VIDEO_MODE;
  assign drain = !FM_WR_VALID || FM_WR_READY;

  sbh_fifo #(
    .WIDTH (SBH_DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_word),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data)
  );

  // output stage moves words on without host action
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FM_WR_VALID  <= 1'b0;
      FM_WR_DATA   <= SBH_LATCH_RST;
      HOST_WR_BUSY <= 1'b0;
    end else begin
      if (drain) begin
        FM_WR_VALID <= fifo_out_valid;
        FM_WR_DATA  <= fifo_out_data;
      end
      // a push while full is lost; busy warns the host first
      HOST_WR_BUSY <= !fifo_in_ready;
    end
  end

  // ****************************************************
  // read path with read latch
  // ****************************************************
  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_FETCH = 3'b010,
    RD_DRIVE = 3'b100
  } sbh_rdst_type;

  sbh_rdst_type rd_st_r;
  logic [17:0]  rd_latch_r;

  // read strobe low: drive; its rise prefetches next memory word
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_st_r           <= RD_IDLE;
      HOST_DATA_PINS_OE <= 1'b0;
      HOST_DATA_PINS_O  <= '0;
      FM_RD_REQ         <= 1'b0;
      rd_latch_r        <= SBH_LATCH_RST;
    end else begin
      FM_RD_REQ <= 1'b0;
      if (any_wr && !wr_dnc) begin
        rd_latch_r <= SBH_LATCH_RST;
      end
      case (rd_st_r)
        RD_IDLE: begin
          if (rd_start) begin
            rd_st_r           <= RD_DRIVE;
            HOST_DATA_PINS_OE <= 1'b1;
            if (!s2_r.dnc) begin
              HOST_DATA_PINS_O <= place_reg(fmt_r, STATUS_IN);
            end else if (INDEX_POINTER_REG == SBH_MEM_INDEX) begin
              HOST_DATA_PINS_O <= place_mem(fmt_r, rd_latch_r);
            end else begin
              HOST_DATA_PINS_O <= place_reg(fmt_r, REG_RD_DATA);
            end
          end
        end
        RD_DRIVE: begin
          if (rd_end || s2_r.cs_n) begin
            rd_st_r           <= RD_IDLE;
            HOST_DATA_PINS_OE <= 1'b0;
            if (s2_r.dnc && INDEX_POINTER_REG == SBH_MEM_INDEX) begin
              rd_st_r   <= RD_FETCH;
              FM_RD_REQ <= 1'b1;
            end
          end
        end
        RD_FETCH: begin
          rd_st_r    <= RD_IDLE;
          rd_latch_r <= FM_RD_DATA;
        end
        default: begin
          rd_st_r <= RD_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // video bypass and status
  // ****************************************************
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      VIDEO_PIX_VALID <= 1'b0;
      VIDEO_PIX       <= '0;
      MODE_INVALID    <= 1'b0;
      SERIAL_OUT      <= 1'b0;
      SERIAL_OUT_OE   <= 1'b0;
    end else begin
      VIDEO_PIX_VALID <= VIDEO_MODE;
      VIDEO_PIX       <= s2_r.data;
      MODE_INVALID    <= !(is_par || is_ser3 || is_ser4);
      // serial reads are not offered; the output stays released
      SERIAL_OUT      <= 1'b0;
      SERIAL_OUT_OE   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/sbh_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// port checker for the host interface
// ****************************************************
module sbh_chk (
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  // host pins
  input wire logic        CHIP_SELECT_N,
  input wire logic        READ_STROBE_N,
  input wire logic [3:0]  BUS_FORMAT_SEL,
  input wire logic        VIDEO_MODE,
  // results
  input wire logic        REG_WR_VALID,
  input wire logic        FM_WR_VALID,
  input wire logic        FM_WR_READY,
  input wire logic [17:0] FM_WR_DATA,
  input wire logic        FM_RD_REQ,
  input wire logic        HOST_DATA_PINS_OE,
  input wire logic        VIDEO_PIX_VALID,
  input wire logic        MODE_INVALID,
  input wire logic        SERIAL_OUT,
  input wire logic        SERIAL_OUT_OE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  // a deselected host moves nothing, whatever the strobes do
  a_cs_quiet: assert property (CHIP_SELECT_N [*5] |->
    !REG_WR_VALID && !FM_RD_REQ)
    else $error("transfer seen while chip select high");
  a_regwr_pulse: assert property (REG_WR_VALID |=> !REG_WR_VALID)
    else $error("register write pulse longer than one cycle");
  a_rdreq_pulse: assert property (FM_RD_REQ |=> !FM_RD_REQ)
    else $error("memory read request longer than one cycle");
  a_oe_release: assert property (READ_STROBE_N [*5] |->
    !HOST_DATA_PINS_OE)
    else $error("data pins driven without a read strobe");
  // pins reach the drive decision three samples late
  a_oe_cause: assert property ($rose(HOST_DATA_PINS_OE) |->
    !$past(READ_STROBE_N, 3) && !$past(CHIP_SELECT_N, 3))
    else $error("data pins driven without a selected read");
  a_fm_hold: assert property (FM_WR_VALID && !FM_WR_READY |=>
    FM_WR_VALID && $stable(FM_WR_DATA))
    else $error("memory word dropped or changed while stalled");
  a_mode_bad: assert property ((BUS_FORMAT_SEL[3:2] == 2'b11) [*7] |->
    MODE_INVALID)
    else $error("unlisted mode code not flagged");
  a_mode_good: assert property ((BUS_FORMAT_SEL[3:2] != 2'b11) [*7] |->
    !MODE_INVALID)
    else $error("listed mode code flagged invalid");
  a_bad_mode_quiet: assert property (MODE_INVALID |-> !REG_WR_VALID)
    else $error("register write under an invalid mode");
  a_video_copy: assert property (VIDEO_MODE |=> VIDEO_PIX_VALID)
    else $error("video pixels not passed through");
  a_video_nostore: assert property (VIDEO_MODE [*8] |->
    !$rose(FM_WR_VALID))
    else $error("video data stored into frame memory");
  a_sout_quiet: assert property (!SERIAL_OUT_OE && !SERIAL_OUT)
    else $error("serial output driven although serial reads are off");
endmodule

bind sbh_host_if sbh_chk chk_u (.CORE_CLK, .ARST_N, .CHIP_SELECT_N,
  .READ_STROBE_N, .BUS_FORMAT_SEL, .VIDEO_MODE, .REG_WR_VALID, .FM_WR_VALID,
  .FM_WR_READY, .FM_WR_DATA, .FM_RD_REQ, .HOST_DATA_PINS_OE,
  .VIDEO_PIX_VALID, .MODE_INVALID, .SERIAL_OUT, .SERIAL_OUT_OE);
`default_nettype wire

// >>> tb/sbh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// microcontroller host: parallel and serial master
// ****************************************************
module sbh_host_model (
  // clock
  input  wire logic        clk,
  // host pins
  output logic             cs_n,
  output logic             dnc,
  output logic             wr_n,
  output logic             rd_n,
  output logic             sin,
  output logic [17:0]      d,
  input  wire logic [17:0] q
);
  // idle: deselected, strobes and serial clock high
  initial begin
    cs_n = 1'b1;
    dnc = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    sin = 1'b0;
    d = 18'h00000;
  end

  // strobe phases of 4 clocks, over the 3 the synchroniser needs
  task automatic wr(input logic c_n, input logic c, input logic [17:0] v);
    @(posedge clk);
    cs_n <= c_n;
    dnc <= c;
    d <= v;
    repeat (3) @(posedge clk);
    wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    d <= ~v; // released bus must not keep the old value
  endtask

  task automatic rd(input logic c, output logic [17:0] v);
    @(posedge clk);
    cs_n <= 1'b0;
    dnc <= c;
    repeat (3) @(posedge clk);
    rd_n <= 1'b0;
    repeat (6) @(posedge clk);
    v = q;
    rd_n <= 1'b1;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
  endtask

  // 3-wire sends the select as first bit; the select pin lies
  task automatic ser(input logic three, input logic c, input logic [7:0] b);
    logic [8:0] w;
    w = three ? {c, b} : {b, 1'b0};
    @(posedge clk);
    cs_n <= 1'b0;
    dnc <= three ? ~c : c;
    repeat (3) @(posedge clk);
    for (int i = 8; i >= (three ? 0 : 1); i--) begin
      wr_n <= 1'b0;
      sin <= w[i]; // msb first
      repeat (3) @(posedge clk);
      wr_n <= 1'b1;
      repeat (3) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
    sin <= ~w[0];
  endtask
endmodule
`default_nettype wire

// >>> tb/sbh_host_if_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sbh_host_if_bench;
  import sbh_pkg::*;
  // ****************************************************
  // signals
  // ****************************************************
  logic          clk;
  logic          arst_n;
  logic [3:0]    fmt;
  logic          video;
  logic          cs_n, dnc, wr_n, rd_n, sin;
  logic [17:0]   hd, pins_i, pins_o, fm_wr_data, v;
  logic          oe, reg_wr_valid, fm_wr_valid, fm_wr_ready, busy;
  logic          pix_valid, mode_bad;
  logic [17:0]   pix;
  logic [7:0]    index;
  sbh_regwr_type reg_wr, reg_last;
  logic [17:0]   mem_q[$];
  int            n_fail, check_count;

  assign pins_i = oe ? pins_o : hd; // shared data wire

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  sbh_host_model hm_u (.clk(clk), .cs_n(cs_n), .dnc(dnc), .wr_n(wr_n),
    .rd_n(rd_n), .sin(sin), .d(hd), .q(pins_i));

  sbh_host_if #(.FIFO_DEPTH(4)) dut_u (
    .CORE_CLK(clk), .ARST_N(arst_n), .CHIP_SELECT_N(cs_n),
    .CMD_DATA_SEL_OR_SERIAL_CLK(dnc), .WRITE_STROBE_OR_SERIAL_CLK(wr_n),
    .READ_STROBE_N(rd_n), .BUS_FORMAT_SEL(fmt), .HOST_DATA_PINS_I(pins_i),
    .HOST_DATA_PINS_O(pins_o), .HOST_DATA_PINS_OE(oe), .SERIAL_IN(sin),
    .SERIAL_OUT(), .SERIAL_OUT_OE(), .VIDEO_MODE(video),
    .REG_WR_VALID(reg_wr_valid), .REG_WR(reg_wr), .INDEX_POINTER_REG(index),
    .REG_RD_DATA(8'h96), .STATUS_IN(8'h3c), .FM_WR_VALID(fm_wr_valid),
    .FM_WR_READY(fm_wr_ready), .FM_WR_DATA(fm_wr_data), .FM_RD_REQ(),
    .FM_RD_DATA(18'h1b2c3), .HOST_WR_BUSY(busy), .VIDEO_PIX_VALID(pix_valid),
    .VIDEO_PIX(pix), .MODE_INVALID(mode_bad));

  // keep the last register write and collect memory words as they leave
  always @(posedge clk) begin
    if (reg_wr_valid)
      reg_last <= reg_wr;
    if (fm_wr_valid && fm_wr_ready)
      mem_q.push_back(fm_wr_data);
  end

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic chk(input string what, input logic [17:0] e, input logic [17:0] s);
    check_count++;
    if (e !== s) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_mem(input int n);
    int k;
    k = 0;
    while (mem_q.size() < n && k < 40) begin
      @(posedge clk);
      k++;
    end
    if (mem_q.size() < n) begin
      n_fail++;
      $display("BAD mem_wait expected %0d seen %0d", n, mem_q.size());
      close_out();
    end
  endtask

  task automatic set_mode(input logic [3:0] m);
    @(posedge clk);
    fmt <= m;
    repeat (8) @(posedge clk);
  endtask

  // memory word as the lanes of each format deliver it, right aligned
  function automatic logic [17:0] lane(input logic [3:0] m, input logic [17:0] d);
    case (m)
      SBH_FMT_P16_I:  return {2'h0, d[15:0]};
      SBH_FMT_P8_I:   return {10'h000, d[7:0]};
      SBH_FMT_P16_II: return {2'h0, d[17:10], d[8:1]};
      SBH_FMT_P8_II:  return {10'h000, d[17:10]};
      SBH_FMT_P9_I:   return {9'h000, d[8:0]};
      SBH_FMT_P9_II:  return {9'h000, d[17:9]};
      default:        return d;
    endcase
  endfunction

  // ****************************************************
  // scenarios
  // ****************************************************
  // every parallel format: index on its register lane, junk elsewhere
  task automatic t_lanes();
    logic [3:0] fm[8] = '{SBH_FMT_P16_I, SBH_FMT_P8_I, SBH_FMT_P16_II,
      SBH_FMT_P8_II, SBH_FMT_P18_I, SBH_FMT_P9_I, SBH_FMT_P18_II, SBH_FMT_P9_II};
    int sh;
    for (int i = 0; i < 8; i++) begin
      set_mode(fm[i]);
      sh = (fm[i][1:0] == 2'b11) ? 10 : (fm[i][1:0] == 2'b10) ? 1 : 0;
      hm_u.wr(1'b0, 1'b0, (18'h22 << sh) | ~(18'hff << sh));
      chk("index", 18'h22, {10'h000, index});
      mem_q.delete();
      hm_u.wr(1'b0, 1'b1, 18'h2d5a6);
      wait_mem(1);
      chk("mem_word", lane(fm[i], 18'h2d5a6), mem_q[0]);
    end
  endtask

  task automatic t_regs();
    hm_u.wr(1'b0, 1'b0, 18'h00017);
    hm_u.wr(1'b0, 1'b1, 18'h0005a);
    chk("reg_wr", 18'h0175a, {2'h0, reg_last});
    hm_u.wr(1'b1, 1'b0, 18'h00033);
    chk("index_cs_high", 18'h17, {10'h000, index});
    hm_u.rd(1'b0, v);
    chk("status", 18'h3c, {10'h000, v[7:0]});
    hm_u.rd(1'b1, v);
    chk("reg_rd", 18'h96, {10'h000, v[7:0]});
  endtask

  task automatic t_memrd();
    hm_u.wr(1'b0, 1'b0, 18'h00022);
    hm_u.rd(1'b1, v); // dummy read out of the latch, checked against its reset value
    chk("mem_dummy", SBH_LATCH_RST, v);
    hm_u.rd(1'b1, v);
    chk("mem_rd", 18'h1b2c3, v);
  endtask

  // stall the memory side until the buffer reports full
  task automatic t_fill();
    mem_q.delete();
    fm_wr_ready <= 1'b0;
    for (int i = 0; i < 6; i++)
      hm_u.wr(1'b0, 1'b1, 18'h00100 + 18'(i));
    chk("busy", 18'h1, {17'h0, busy});
    fm_wr_ready <= 1'b1;
    wait_mem(4);
    for (int i = 0; i < 4; i++)
      chk("fill_word", 18'h00100 + 18'(i), mem_q[i]);
  endtask

  task automatic t_invalid();
    set_mode(4'hc);
    chk("mode_bad", 18'h1, {17'h0, mode_bad});
    hm_u.wr(1'b0, 1'b0, 18'h00044);
    chk("index_bad_mode", 18'h22, {10'h000, index});
    mem_q.delete();
    hm_u.wr(1'b0, 1'b1, 18'h00055);
    repeat (4) @(posedge clk);
    chk("mem_bad_mode", 18'h0, 18'(mem_q.size()));
    set_mode(SBH_FMT_P18_I);
  endtask

  task automatic t_video();
    mem_q.delete();
    video <= 1'b1;
    hm_u.wr(1'b0, 1'b1, 18'h2aaaa);
    hm_u.wr(1'b0, 1'b0, 18'h00017);
    repeat (10) @(posedge clk);
    chk("video_stored", 18'h0, 18'(mem_q.size()));
    chk("video_pix", 18'h3ffe8, pix);
    chk("index_video", 18'h22, {10'h000, index});
    video <= 1'b0;
  endtask

  task automatic t_serial();
    set_mode(4'h6);
    hm_u.ser(1'b0, 1'b0, 8'h17);
    chk("ser4_index", 18'h17, {10'h000, index});
    set_mode(4'h4);
    hm_u.ser(1'b1, 1'b0, 8'h3b);
    hm_u.ser(1'b1, 1'b1, 8'h69);
    chk("ser3_reg_wr", 18'h03b69, {2'h0, reg_last});
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    arst_n = 1'b0;
    fmt = SBH_FMT_P18_I;
    video = 1'b0;
    fm_wr_ready = 1'b1;
    n_fail = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk("index_reset", 18'h0, {10'h000, index});
    repeat (4) @(posedge clk);
    t_lanes();
    set_mode(SBH_FMT_P18_I);
    t_regs();
    t_memrd();
    t_fill();
    t_invalid();
    t_video();
    t_serial();
    close_out();
  end
endmodule
`default_nettype wire
